// ===== verilog/hmc_cfg.svh
// Function
// - enable pin high stops boost, keeps registers
// - wake only above alert level, not sleeping
// - source below setpoint halts boost
// - storage rail at regulation halts boost
// - count cycles per window, publish two bytes
// - skip count update when boost was halted, except by source below setpoint
// - new count sets count ready flag
// - periodic or forced open-circuit sample, halting boost
// - setpoint is sample times fraction
// - sample register resets to 29, fraction 26/32
// - adaptive window scaled by last count
// - adaptive interval adapts tracking period
// - first count after reset is discarded
// - timing register selects window and interval
// - count doubling or halving forces new sample
// - forced sample stored, flags ready, event raised
`ifndef HMC_CFG_SVH
`define HMC_CFG_SVH

// register map
`define HMC_ADDR_STATUS  8'h01
`define HMC_ADDR_ALERT   8'h04
`define HMC_ADDR_FRAC    8'h06
`define HMC_ADDR_TIMING  8'h07
`define HMC_ADDR_HALT    8'h08
`define HMC_ADDR_VOC     8'h09
`define HMC_ADDR_CNTH    8'h0a
`define HMC_ADDR_CNTL    8'h0b

// field positions
`define HMC_ST_CNT_RDY   4
`define HMC_ST_SMP_RDY   3
`define HMC_TM_FORCE     7
`define HMC_TM_WIN_MSB   5
`define HMC_TM_WIN_LSB   4
`define HMC_TM_AWIN      3
`define HMC_TM_AINT      2
`define HMC_TM_INT_MSB   1
`define HMC_TM_INT_LSB   0

// reset values
`define HMC_VOC_RST      8'h1d
`define HMC_FRAC_RST     5'h1a
`define HMC_TIMING_RST   8'h23
`define HMC_ALERT_RST    3'h0

// arithmetic and timing
`define HMC_FRAC_SHIFT   5
`define HMC_CNT_LOW      16'h000d
`define HMC_CNT_MID      16'h001a
`define HMC_CNT_HIGH     16'h0034
`define HMC_WIN_BASE     7'h04
`define HMC_INT_BASE     8'h08
`define HMC_CLK_NS       100
`define HMC_TICK_NS      3125000

`endif

// ===== verilog/hmc_pkg.sv
package hmc_pkg;

  // tracking sequencer states
  typedef enum logic [1:0] {
    st_run,
    st_sample,
    st_convert
  } hmc_state_t;

  // count level band, used for window and interval scaling
  typedef enum logic [1:0] {
    band_low,
    band_mid,
    band_upper,
    band_top
  } hmc_band_t;

endpackage

// ===== verilog/hmc_tb_if.sv
`timescale 1ns/10ps
`default_nettype none

interface hmc_tb_if;
  logic [6:0] win_ticks;
  logic       restart;
  logic       win_end;

  modport ctrl  (output win_ticks, output restart, input win_end);
  modport timer (input win_ticks, input restart, output win_end);
endinterface

`default_nettype wire

// ===== verilog/hmc_timebase.sv
`timescale 1ns/10ps
`default_nettype none
`include "hmc_cfg.svh"

module hmc_timebase #(
  parameter int TICK_CYCLES = `HMC_TICK_NS / `HMC_CLK_NS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // window timing toward the controller
  hmc_tb_if.timer   tb
);

  initial begin
    if (TICK_CYCLES < 1 || TICK_CYCLES > 1048575) begin
      $error("hmc_timebase: TICK_CYCLES out of range");
    end
  end

  logic [19:0] div_q;
  logic [19:0] div_d;
  logic [6:0]  win_q;
  logic [6:0]  win_d;
  logic        end_q;
  logic        end_d;
  logic        tick;

  assign tb.win_end = end_q;

  ////////////////////////////////////////////////////////////////////////////
  // divider to base tick, then ticks to window end
  always_comb begin
    div_d = div_q + 20'h00001;
    win_d = win_q;
    end_d = 1'b0;
    tick  = (div_q == 20'(TICK_CYCLES - 1));
    if (tick) begin
      div_d = 20'h00000;
      win_d = win_q + 7'h01;
      // length may shrink mid-window, so compare with >=
      if (win_q + 7'h01 >= tb.win_ticks) begin
        win_d = 7'h00;
        end_d = 1'b1;
      end
    end
    if (tb.restart) begin
      div_d = 20'h00000;
      win_d = 7'h00;
      end_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_q <= 20'h00000;
      win_q <= 7'h00;
      end_q <= 1'b0;
    end else begin
      div_q <= div_d;
      win_q <= win_d;
      end_q <= end_d;
    end
  end

endmodule

`default_nettype wire

// ===== verilog/hmc_peak_power_tracking_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "hmc_cfg.svh"

module hmc_peak_power_tracking_ctrl
  import hmc_pkg::*;
#(
  parameter int TICK_CYCLES = `HMC_TICK_NS / `HMC_CLK_NS
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // enable pin, active low
  input  wire logic       enable_n,
  // register port behind the serial interface
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] rd_data_q,
  // power stage comparators and cycle pulse
  input  wire logic       boost_cycle,
  input  wire logic       src_below_point,
  input  wire logic       rail_at_point,
  input  wire logic       rail_above_alert,
  input  wire logic       thermal_halt,
  input  wire logic       sleep_mode,
  // power stage controls
  output logic            boost_en_q,
  output logic      [7:0] src_setpoint_q,
  output logic      [2:0] rail_alert_level_q,
  // open-circuit converter
  output logic            adc_start_q,
  input  wire logic       adc_valid,
  input  wire logic [7:0] adc_code,
  // events and wake
  output logic            sample_event_q,
  output logic            wake_q
);

  initial begin
    if (TICK_CYCLES < 1) begin
      $error("hmc_peak_power_tracking_ctrl: TICK_CYCLES must be at least 1");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // harvest level band from a count
  function automatic hmc_band_t count_band(input logic [15:0] cnt);
    if (cnt < `HMC_CNT_LOW) begin
      count_band = band_low;
    end else if (cnt <= `HMC_CNT_MID) begin
      count_band = band_mid;
    end else if (cnt <= `HMC_CNT_HIGH) begin
      count_band = band_upper;
    end else begin
      count_band = band_top;
    end
  endfunction

  // window length in base ticks
  function automatic logic [6:0] win_len(input logic [1:0]  sel,
                                         input logic        adapt,
                                         input logic [15:0] cnt);
    logic [6:0] base;
    base    = `HMC_WIN_BASE << sel;
    win_len = base;
    if (adapt) begin
      unique case (count_band(cnt))
        band_low:   win_len = base << 1;
        band_mid:   win_len = base;
        band_upper: win_len = base >> 1;
        band_top:   win_len = base >> 2;
      endcase
    end
  endfunction

  // tracking interval in windows
  function automatic logic [7:0] int_len(input logic [1:0]  sel,
                                         input logic        adapt,
                                         input logic [15:0] cnt);
    logic [7:0] base;
    base    = `HMC_INT_BASE << sel;
    int_len = base;
    if (adapt) begin
      unique case (count_band(cnt))
        band_low:   int_len = base << 1;
        band_mid:   int_len = base;
        band_upper: int_len = base;
        band_top:   int_len = base >> 1;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  hmc_state_t  state_q, state_d;
  logic [4:0]  frac_q, frac_d;
  logic [7:0]  timing_q, timing_d;
  logic [2:0]  alert_d;
  logic        sw_halt_q, sw_halt_d;
  logic [7:0]  voc_q, voc_d;
  logic [15:0] count_q, count_d;
  logic [15:0] run_cnt_q, run_cnt_d;
  logic        halted_q, halted_d;
  logic        first_done_q, first_done_d;
  logic        count_valid_q, count_valid_d;
  logic        cnt_rdy_q, cnt_rdy_d;
  logic        smp_rdy_q, smp_rdy_d;
  logic        pend_q, pend_d;
  logic [7:0]  int_cnt_q, int_cnt_d;
  logic [7:0]  rd_data_d;
  logic        boost_en_d;
  logic [7:0]  setpoint_d;
  logic        adc_start_d;
  logic        sample_event_d;
  logic        wake_d;
  logic        running;
  logic        halt_cause;
  logic        go_sample;
  logic [12:0] product;
  logic [16:0] new_dbl;
  logic [16:0] old_dbl;
  logic [7:0]  int_next;

  hmc_tb_if tb ();

  hmc_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timebase (
    .clk     (clk),
    .reset_n (reset_n),
    .tb      (tb.timer)
  );

  ////////////////////////////////////////////////////////////////////////////
  // window control toward the timebase

  assign tb.win_ticks = win_len(timing_q[`HMC_TM_WIN_MSB:`HMC_TM_WIN_LSB],
                                timing_q[`HMC_TM_AWIN], count_q);
  // timer held in shutdown
  // timer also held while converting so the next window starts clean
  assign tb.restart   = !running || (state_q == st_convert);

  ////////////////////////////////////////////////////////////////////////////
  // next-value logic

  always_comb begin
    state_d        = state_q;
    frac_d         = frac_q;
    timing_d       = timing_q;
    alert_d        = rail_alert_level_q;
    sw_halt_d      = sw_halt_q;
    voc_d          = voc_q;
    count_d        = count_q;
    run_cnt_d      = run_cnt_q;
    halted_d       = halted_q;
    first_done_d   = first_done_q;
    count_valid_d  = count_valid_q;
    cnt_rdy_d      = cnt_rdy_q;
    smp_rdy_d      = smp_rdy_q;
    pend_d         = pend_q;
    int_cnt_d      = int_cnt_q;
    rd_data_d      = rd_data_q;
    adc_start_d    = 1'b0;
    sample_event_d = 1'b0;
    go_sample      = 1'b0;
    running        = !enable_n;
    int_next       = int_cnt_q + 8'h01;
    new_dbl        = {run_cnt_q, 1'b0};
    old_dbl        = {count_q, 1'b0};
    // any halt cause except source below setpoint taints this window
    halt_cause     = thermal_halt || sleep_mode || sw_halt_q ||
                     rail_at_point || (state_q != st_run);

    // register reads; status flags clear on read
    if (reg_rd) begin
      unique case (reg_addr)
        `HMC_ADDR_STATUS: begin
          rd_data_d = 8'h00;
          rd_data_d[`HMC_ST_CNT_RDY] = cnt_rdy_q;
          rd_data_d[`HMC_ST_SMP_RDY] = smp_rdy_q;
          cnt_rdy_d = 1'b0;
          smp_rdy_d = 1'b0;
        end
        `HMC_ADDR_ALERT:  rd_data_d = {5'h00, rail_alert_level_q};
        `HMC_ADDR_FRAC:   rd_data_d = {3'h0, frac_q};
        `HMC_ADDR_TIMING: rd_data_d = timing_q;
        `HMC_ADDR_HALT:   rd_data_d = {7'h00, sw_halt_q};
        `HMC_ADDR_VOC:    rd_data_d = voc_q;
        `HMC_ADDR_CNTH:   rd_data_d = count_q[15:8];
        `HMC_ADDR_CNTL:   rd_data_d = count_q[7:0];
        default:          rd_data_d = 8'h00;
      endcase
    end

    // register writes; hardware updates below take priority
    if (reg_wr) begin
      unique case (reg_addr)
        `HMC_ADDR_ALERT:  alert_d   = reg_wdata[2:0];
        `HMC_ADDR_FRAC:   frac_d    = reg_wdata[4:0];
        `HMC_ADDR_HALT:   sw_halt_d = reg_wdata[0];
        // software write replaces the sample value
        `HMC_ADDR_VOC:    voc_d     = reg_wdata;
        `HMC_ADDR_TIMING: begin
          timing_d = reg_wdata;
          timing_d[`HMC_TM_FORCE] = 1'b0;
          if (reg_wdata[`HMC_TM_FORCE]) begin
            pend_d = 1'b1;
          end
        end
        default: ;
      endcase
    end

    if (!running) begin
      state_d   = st_run;
      run_cnt_d = 16'h0000;
      halted_d  = 1'b0;
      pend_d    = 1'b0;
      int_cnt_d = 8'h00;
    end else begin
      if (boost_cycle && run_cnt_q != 16'hffff) begin
        run_cnt_d = run_cnt_q + 16'h0001;
      end
      if (halt_cause) begin
        halted_d = 1'b1;
      end
      unique case (state_q)
        st_run: begin
          if (tb.win_end) begin
            run_cnt_d = 16'h0000;
            halted_d  = 1'b0;
            int_cnt_d = int_next;
            if (int_next >= int_len(
                  timing_q[`HMC_TM_INT_MSB:`HMC_TM_INT_LSB],
                  timing_q[`HMC_TM_AINT], count_q)) begin
              int_cnt_d = 8'h00;
              go_sample = 1'b1;
            end
            // pending request served at the window end
            if (pend_q || pend_d) begin
              go_sample = 1'b1;
            end
            if (!halted_q && !halt_cause) begin
              if (!first_done_q) begin
                first_done_d = 1'b1;
              end else begin
                count_d       = run_cnt_q;
                count_valid_d = 1'b1;
                cnt_rdy_d     = 1'b1;
                if (count_valid_q &&
                    ({1'b0, run_cnt_q} > old_dbl ||
                     new_dbl < {1'b0, count_q})) begin
                  int_cnt_d = 8'h00;
                  go_sample = 1'b1;
                end
              end
            end
            if (go_sample) begin
              pend_d  = 1'b0;
              state_d = st_sample;
            end
          end
        end
        st_sample: begin
          // boost held off for one window, then convert
          if (tb.win_end) begin
            adc_start_d = 1'b1;
            state_d     = st_convert;
          end
        end
        st_convert: begin
          if (adc_valid) begin
            // code stored as ten millivolt steps
            voc_d          = adc_code;
            smp_rdy_d      = 1'b1;
            sample_event_d = 1'b1;
            run_cnt_d      = 16'h0000;
            halted_d       = 1'b0;
            state_d        = st_run;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs toward the power stage

  // setpoint is sample scaled by fraction over 32
  assign product    = voc_q * frac_q;
  assign setpoint_d = product[`HMC_FRAC_SHIFT +: 8];

  always_comb begin
    boost_en_d = running && (state_q == st_run) && !src_below_point &&
                 !rail_at_point && !thermal_halt && !sleep_mode &&
                 !sw_halt_q;
    // wake only when rail high and awake
    wake_d     = running && !sleep_mode && rail_above_alert;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q            <= st_run;
      frac_q             <= `HMC_FRAC_RST;
      timing_q           <= `HMC_TIMING_RST;
      rail_alert_level_q <= `HMC_ALERT_RST;
      sw_halt_q          <= 1'b0;
      voc_q              <= `HMC_VOC_RST;
      count_q            <= 16'h0000;
      run_cnt_q          <= 16'h0000;
      halted_q           <= 1'b0;
      first_done_q       <= 1'b0;
      count_valid_q      <= 1'b0;
      cnt_rdy_q          <= 1'b0;
      smp_rdy_q          <= 1'b0;
      pend_q             <= 1'b0;
      int_cnt_q          <= 8'h00;
      rd_data_q          <= 8'h00;
      boost_en_q         <= 1'b0;
      src_setpoint_q     <= 8'h00;
      adc_start_q        <= 1'b0;
      sample_event_q     <= 1'b0;
      wake_q             <= 1'b0;
    end else begin
      state_q            <= state_d;
      frac_q             <= frac_d;
      timing_q           <= timing_d;
      rail_alert_level_q <= alert_d;
      sw_halt_q          <= sw_halt_d;
      voc_q              <= voc_d;
      count_q            <= count_d;
      run_cnt_q          <= run_cnt_d;
      halted_q           <= halted_d;
      first_done_q       <= first_done_d;
      count_valid_q      <= count_valid_d;
      cnt_rdy_q          <= cnt_rdy_d;
      smp_rdy_q          <= smp_rdy_d;
      pend_q             <= pend_d;
      int_cnt_q          <= int_cnt_d;
      rd_data_q          <= rd_data_d;
      boost_en_q         <= boost_en_d;
      src_setpoint_q     <= setpoint_d;
      adc_start_q        <= adc_start_d;
      sample_event_q     <= sample_event_d;
      wake_q             <= wake_d;
    end
  end

endmodule

`default_nettype wire

// ===== verification/hmc_peak_power_tracking_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none

module hmc_peak_power_tracking_ctrl_sva #(
  parameter int TICK_CYCLES = 31250
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // pins and register port
  input wire logic       enable_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] rd_data_q,
  // power stage side
  input wire logic       src_below_point,
  input wire logic       rail_at_point,
  input wire logic       rail_above_alert,
  input wire logic       sleep_mode,
  input wire logic       boost_en_q,
  input wire logic [7:0] src_setpoint_q,
  input wire logic       adc_start_q,
  input wire logic       adc_valid,
  input wire logic       sample_event_q,
  input wire logic       wake_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////
  // conversion handshake, bounded so a lost answer is not waited on
  sequence s_convert;
    adc_start_q ##[1:60] adc_valid;
  endsequence

  // two cycles of shutdown leave no room for a late switching cycle
  a_shutdown_halt: assert property (enable_n [*2] |-> !boost_en_q)
    else $error("boost on in shutdown");
  // wake is the one-cycle-late product of enable, sleep and rail level
  a_wake_follows: assert property ($past(reset_n) |->
    wake_q == ($past(rail_above_alert) && !$past(sleep_mode)
               && !$past(enable_n)))
    else $error("wake level wrong");
  a_src_halt: assert property (src_below_point |=> !boost_en_q)
    else $error("boost on with source low");
  a_rail_halt: assert property (rail_at_point |=> !boost_en_q)
    else $error("boost on with rail full");
  a_start_halted: assert property (adc_start_q |-> !boost_en_q)
    else $error("sampling while boost runs");
  a_sample_stored: assert property (s_convert |=> sample_event_q)
    else $error("sample not stored");
  a_event_cause: assert property (sample_event_q |-> $past(adc_valid))
    else $error("sample event without result");
  a_setpoint_reset: assert property ($rose(reset_n) |=>
    src_setpoint_q == 8'h17)
    else $error("reset setpoint wrong");
  a_read_unmapped: assert property (reg_rd && !(reg_addr inside
    {8'h01, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b})
    |=> rd_data_q == 8'h00)
    else $error("unmapped read not zero");
endmodule

bind hmc_peak_power_tracking_ctrl hmc_peak_power_tracking_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
  .clk(clk), .reset_n(reset_n), .enable_n(enable_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .rd_data_q(rd_data_q),
  .src_below_point(src_below_point), .rail_at_point(rail_at_point),
  .rail_above_alert(rail_above_alert), .sleep_mode(sleep_mode),
  .boost_en_q(boost_en_q), .src_setpoint_q(src_setpoint_q),
  .adc_start_q(adc_start_q), .adc_valid(adc_valid),
  .sample_event_q(sample_event_q), .wake_q(wake_q)
);

`default_nettype wire

// ===== verification/hmc_stage_model.sv
`timescale 1ns/10ps
`default_nettype none

module hmc_stage_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // controls from the block
  input  wire logic       boost_en_q,
  input  wire logic       adc_start_q,
  // answer chosen by the bench
  input  wire logic [7:0] smp_code,
  input  wire logic [3:0] smp_delay,
  // switching pulses and converter answer
  output logic            boost_cycle,
  output logic            adc_valid,
  output logic      [7:0] adc_code
);
  logic [3:0] wait_q;
  logic       busy_q;

  ////////////////////////////////////////
  // switches every other cycle while allowed; converter answers after
  // smp_delay cycles and scrambles its bus otherwise, so stale data shows
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      boost_cycle <= 1'b0;
      adc_valid <= 1'b0;
      adc_code <= 8'h00;
      busy_q <= 1'b0;
      wait_q <= 4'h0;
    end else begin
      boost_cycle <= boost_en_q && !boost_cycle;
      adc_valid <= 1'b0;
      adc_code <= ~adc_code;
      if (adc_start_q) begin
        busy_q <= 1'b1;
        wait_q <= smp_delay;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        adc_valid <= 1'b1;
        adc_code <= smp_code;
      end
    end
  end
endmodule

`default_nettype wire

// ===== verification/hmc_peak_power_tracking_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none

module hmc_peak_power_tracking_ctrl_tb;
  logic        clk, reset_n, enable_n, reg_wr, reg_rd, boost_cycle;
  logic        src_below_point, rail_at_point, rail_above_alert;
  logic        thermal_halt, sleep_mode, boost_en_q, adc_start_q;
  logic        adc_valid, sample_event_q, wake_q;
  logic  [7:0] reg_addr, reg_wdata, rd_data_q, src_setpoint_q, rdv;
  logic  [7:0] adc_code, smp_code;
  logic  [3:0] smp_delay;
  logic  [2:0] rail_alert_level_q;
  logic [15:0] cnt, top;
  int          num_errors, tests_run, n;

  ////////////////////////////////////////
  // short tick keeps a 16-tick window at 64 cycles
  hmc_peak_power_tracking_ctrl #(.TICK_CYCLES(4)) dut (
    .clk(clk), .reset_n(reset_n), .enable_n(enable_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .rd_data_q(rd_data_q),
    .boost_cycle(boost_cycle), .src_below_point(src_below_point),
    .rail_at_point(rail_at_point), .rail_above_alert(rail_above_alert),
    .thermal_halt(thermal_halt), .sleep_mode(sleep_mode),
    .boost_en_q(boost_en_q), .src_setpoint_q(src_setpoint_q),
    .rail_alert_level_q(rail_alert_level_q), .adc_start_q(adc_start_q),
    .adc_valid(adc_valid), .adc_code(adc_code),
    .sample_event_q(sample_event_q), .wake_q(wake_q));
  hmc_stage_model u_stage (
    .clk(clk), .reset_n(reset_n), .boost_en_q(boost_en_q),
    .adc_start_q(adc_start_q), .smp_code(smp_code),
    .smp_delay(smp_delay), .boost_cycle(boost_cycle),
    .adc_valid(adc_valid), .adc_code(adc_code));

  ////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h want %h", $time, msg, seen, exp);
    end
  endtask
  // register strobes rise and fall on edges, one byte each
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rdv = rd_data_q;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, string m);
    rd(a);
    check(rdv, e, m);
  endtask
  // polls status until a count lands; the read clears the flag
  task automatic get_count;
    rdv = 8'h00;
    for (n = 0; n < 400 && rdv[4] !== 1'b1; n++) rd(8'h01);
    check(rdv[4], 1'b1, "count ready");
    rd(8'h0a);
    cnt[15:8] = rdv;
    rd(8'h0b);
    cnt[7:0] = rdv;
  endtask

  ////////////////////////////////////////
  task automatic t_reset;
    rdchk(8'h09, 8'h1d, "voc");
    rdchk(8'h06, 8'h1a, "frac");
    rdchk(8'h07, 8'h23, "timing");
    rdchk(8'h05, 8'h00, "unmapped");
    check(src_setpoint_q, 8'h17, "setpoint");
    repeat (80) @(posedge clk);
    rdchk(8'h01, 8'h00, "first count");
    $display("t_reset done");
  endtask
  // one pulse per two cycles: window of 16 cycles << sel gives 8 << sel
  task automatic t_window;
    for (int s = 0; s < 3; s++) begin
      wr(8'h07, 8'(s << 4));
      get_count();
      get_count();
      check(cnt inside {[(8 << s) - 1:(8 << s) + 1]}, 1, "count");
    end
    $display("t_window done");
  endtask
  // low counts double the window, so some result reaches about 16
  task automatic t_adapt;
    wr(8'h07, 8'h08);
    get_count();
    top = 16'h0000;
    repeat (4) begin
      get_count();
      if (cnt > top) top = cnt;
    end
    check(top inside {[15:17]}, 1, "adaptive count");
    wr(8'h07, 8'h00);
    $display("t_adapt done");
  endtask
  task automatic t_taint;
    // 64-window interval keeps sample flags out of the status reads
    wr(8'h07, 8'h03);
    @(posedge clk);
    thermal_halt <= 1'b1;
    repeat (40) @(posedge clk);
    rd(8'h01);
    repeat (40) @(posedge clk);
    rdchk(8'h01, 8'h00, "tainted count");
    @(posedge clk);
    thermal_halt <= 1'b0;
    $display("t_taint done");
  endtask
  // slow converter answer to a software request
  task automatic t_force;
    @(posedge clk);
    smp_code <= 8'h50;
    smp_delay <= 4'd9;
    wr(8'h07, 8'h80);
    for (n = 0; n < 80 && adc_start_q !== 1'b1; n++) @(negedge clk);
    check(adc_start_q, 1'b1, "start");
    check(boost_en_q, 1'b0, "halted");
    for (n = 0; n < 40 && sample_event_q !== 1'b1; n++) @(negedge clk);
    check(sample_event_q, 1'b1, "event");
    rdchk(8'h09, 8'h50, "sample");
    rdchk(8'h07, 8'h00, "force bit");
    rd(8'h01);
    check(rdv[3], 1'b1, "sample ready");
    check(src_setpoint_q, 8'h41, "setpoint");
    $display("t_force done");
  endtask
  task automatic t_shutdown;
    @(posedge clk);
    enable_n <= 1'b1;
    rail_above_alert <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(boost_en_q, 1'b0, "boost");
    check(wake_q, 1'b0, "wake");
    wr(8'h09, 8'h40);
    rdchk(8'h09, 8'h40, "voc");
    check(src_setpoint_q, 8'h34, "setpoint");
    wr(8'h06, 8'h10);
    rdchk(8'h06, 8'h10, "frac");
    check(src_setpoint_q, 8'h20, "setpoint");
    rd(8'h0a);
    cnt[7:0] = rdv;
    wr(8'h0a, ~cnt[7:0]);
    rdchk(8'h0a, cnt[7:0], "read only");
    wr(8'h06, 8'h1a);
    // long windows against short stored counts, interval far away
    wr(8'h07, 8'h23);
    @(posedge clk);
    enable_n <= 1'b0;
    for (n = 0; n < 200 && adc_start_q !== 1'b1; n++) @(negedge clk);
    check(adc_start_q, 1'b1, "doubling forces sample");
    $display("t_shutdown done");
  endtask
  task automatic t_wake;
    wr(8'h04, 8'h05);
    repeat (2) @(posedge clk);
    #1 check(rail_alert_level_q, 3'h5, "level");
    check(wake_q, 1'b1, "wake");
    @(posedge clk);
    sleep_mode <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check(wake_q, 1'b0, "sleep wake");
    @(posedge clk);
    sleep_mode <= 1'b0;
    src_below_point <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(boost_en_q, 1'b0, "source low");
    @(posedge clk);
    src_below_point <= 1'b0;
    rail_at_point <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check(boost_en_q, 1'b0, "rail full");
    @(posedge clk);
    rail_at_point <= 1'b0;
    $display("t_wake done");
  endtask
  // counts below 13 stretch the 8-window interval to 16 windows of 16
  // cycles, plus one sample window between two converter starts
  task automatic t_interval;
    wr(8'h07, 8'h04);
    for (n = 0; n < 400 && adc_start_q !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    for (n = 0; n < 400 && adc_start_q !== 1'b1; n++) @(negedge clk);
    check(n inside {[250:300]}, 1, "adaptive interval");
    $display("t_interval done");
  endtask

  ////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // watchdog well beyond the few thousand cycles the run needs
  initial begin
    #2000000;
    num_errors++;
    print_verdict();
  end
  initial begin
    {reset_n, enable_n, reg_wr, reg_rd, thermal_halt, sleep_mode} = '0;
    {src_below_point, rail_at_point, rail_above_alert} = '0;
    {reg_addr, reg_wdata, smp_code, smp_delay} = {24'h000033, 4'h1};
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_window();
    t_adapt();
    t_taint();
    t_force();
    t_shutdown();
    t_wake();
    t_interval();
    print_verdict();
  end
endmodule

`default_nettype wire
